// >>> verilog/pcrc_regs.svh
// Register offsets, field positions, reset values and polynomials of the CRC unit.
// Assumes inclusion by bare name from the package and the unit's modules.
// What this block does
// - Control bits 6:4 pick the CRC: 0 is 16-bit, 1 is 32-bit, rest reserved.
// - Control bit 0 enables the engine; cleared it stops the CRC logic.
// - A write to the word input folds all 32 written bits into the CRC.
// - A write to the halfword input folds only bits 15:0 into the CRC.
// - A write to the byte input folds only bits 7:0 into the CRC.
// - Reading any data input register returns the addressed CRC byte.
// - In 32-bit mode the result register shows the whole 32-bit CRC.
// - In 16-bit mode the result register shows the 16-bit CRC in bits 15:0.
// - A seed write loads the whole written value into the CRC register.
// - Reading the seed register returns the last value written to it.
// - The seed reaches the CRC register within one clock of the write.
// - 16-bit mode uses polynomial x^16 + x^12 + x^5 + 1.
// - 32-bit mode uses the Ethernet 32-bit generator polynomial.
// - No final XOR or inversion is applied to the result.
// - Data enters LSB first; seed order follows bit order select; result read MSB first.
`ifndef PCRC_REGS_SVH
`define PCRC_REGS_SVH

`define PCRC_ADDR_W 5
`define PCRC_OFS_CONFIG 5'h00
`define PCRC_OFS_WORD 5'h04
`define PCRC_OFS_HALF 5'h08
`define PCRC_OFS_BYTE 5'h0C
`define PCRC_OFS_RESULT 5'h10
`define PCRC_OFS_SEED 5'h14

`define PCRC_BIT_ENABLE 0
`define PCRC_BIT_ORDER 2
`define PCRC_POLY_LO 4
`define PCRC_POLY_HI 6

`define PCRC_POLY_SEL_16 3'h0
`define PCRC_POLY_SEL_32 3'h1

`define PCRC_RST_CONFIG 32'h00000000
`define PCRC_RST_RESULT 32'h0000FFFF
`define PCRC_RST_SEED 32'h00000000

`define PCRC_POLY16 16'h1021
`define PCRC_POLY32 32'h04C11DB7

`endif

// >>> verilog/pcrc_pkg.sv
// Types shared by the CRC unit and its parallel update engine.
// Assumes pcrc_regs.svh is on the include path.
package pcrc_pkg;
  `include "pcrc_regs.svh"

  typedef enum logic [1:0] {
    PCRC_DW_32,
    PCRC_DW_16,
    PCRC_DW_8
  } pcrc_width_t;

  typedef struct packed {
    logic [2:0] poly_width_select;
    logic bit_order_select;
    logic enable;
  } pcrc_cfg_t;
endpackage

// >>> verilog/pcrc_engine.sv
// Combinational parallel CRC update for 8, 16 or 32 data bits per step.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/100ps
`include "pcrc_regs.svh"
module pcrc_engine (
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_in,
  input wire pcrc_pkg::pcrc_width_t width,
  input wire logic is_crc32,
  output logic [31:0] crc_out
);
  // ***********************************
  // Parallel fold
  // ***********************************
  // The loop unrolls into one XOR network per output bit, so the whole
  // word is folded in one clock; the serial form only describes it.
  function automatic logic [31:0] pcrc_fold(input logic [31:0] crc, input logic [31:0] d,
                                            input int nbits, input logic wide);
    logic [31:0] c;
    logic fb;
    c = crc;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (i < nbits) begin
        if (wide) begin
          fb = c[31] ^ d[i];
          c = {c[30:0], 1'b0} ^ (fb ? `PCRC_POLY32 : 32'h00000000);
        end else begin
          fb = c[15] ^ d[i];
          c[15:0] = {c[14:0], 1'b0} ^ (fb ? `PCRC_POLY16 : 16'h0000);
        end
      end
    end
    return c;
  endfunction

  always_comb begin
    case (width)
      pcrc_pkg::PCRC_DW_32: crc_out = pcrc_fold(crc_in, data_in, 32, is_crc32);
      pcrc_pkg::PCRC_DW_16: crc_out = pcrc_fold(crc_in, data_in, 16, is_crc32);
      pcrc_pkg::PCRC_DW_8: crc_out = pcrc_fold(crc_in, data_in, 8, is_crc32);
      default: crc_out = crc_in;
    endcase
  end
endmodule

// >>> verilog/pcrc_unit.sv
// CRC unit: configuration, data input, result and seed registers on APB.
// Assumes an APB3 master on core_clk; all inputs are synchronous to core_clk.
`timescale 1ns/100ps
`include "pcrc_regs.svh"
module pcrc_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCRC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ***********************************
  // Helpers
  // ***********************************
  function automatic logic [31:0] pcrc_rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  // Address decode used only for pslverr; the write path compares word_addr itself
  function automatic logic pcrc_mapped(input logic [`PCRC_ADDR_W-1:0] a);
    case ({a[`PCRC_ADDR_W-1:2], 2'b00})
      `PCRC_OFS_CONFIG, `PCRC_OFS_WORD, `PCRC_OFS_HALF,
      `PCRC_OFS_BYTE, `PCRC_OFS_RESULT, `PCRC_OFS_SEED: pcrc_mapped = 1'b1;
      default: pcrc_mapped = 1'b0;
    endcase
  endfunction

  // ***********************************
  // State
  // ***********************************
  pcrc_pkg::pcrc_cfg_t cfg;
  pcrc_pkg::pcrc_cfg_t next_cfg;
  logic [31:0] crc;
  logic [31:0] next_crc;
  logic [31:0] seed;
  logic [31:0] next_seed;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic [`PCRC_ADDR_W-1:0] word_addr;
  logic setup;
  logic wr_access;
  logic mode_valid;
  logic is_crc32;
  pcrc_pkg::pcrc_width_t width;
  logic data_write;
  logic [31:0] engine_out;
  logic [31:0] result_view;
  logic [31:0] seed_loaded;
  logic [31:0] seed_rev;
  logic [7:0] addressed_byte;

  assign word_addr = {paddr[`PCRC_ADDR_W-1:2], 2'b00};
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;

  // ***********************************
  // Mode decode
  // ***********************************
  // Reserved width codes keep data writes (not seed writes) out of the CRC register, so a bad setup
  // cannot silently produce a checksum of some undefined polynomial.
  assign is_crc32 = (cfg.poly_width_select == `PCRC_POLY_SEL_32);
  assign mode_valid = is_crc32 | (cfg.poly_width_select == `PCRC_POLY_SEL_16);

  always_comb begin
    data_write = wr_access;
    case (word_addr)
      `PCRC_OFS_WORD: width = pcrc_pkg::PCRC_DW_32;
      `PCRC_OFS_HALF: width = pcrc_pkg::PCRC_DW_16;
      `PCRC_OFS_BYTE: width = pcrc_pkg::PCRC_DW_8;
      default: begin
        width = pcrc_pkg::PCRC_DW_32;
        data_write = 1'b0;
      end
    endcase
  end

  pcrc_engine u_engine (
    .crc_in(crc),
    .data_in(pwdata),
    .width(width),
    .is_crc32(is_crc32),
    .crc_out(engine_out)
  );

  // Seed enters MSB first as written, or reversed over the active width
  always_comb begin
    seed_rev = pcrc_rev32(pwdata);
    seed_loaded = pwdata;
    if (cfg.bit_order_select) begin
      if (is_crc32) begin
        seed_loaded = seed_rev;
      end else begin
        seed_loaded = {pwdata[31:16], seed_rev[31:16]};
      end
    end
  end

  // Result shown as held, no final XOR, upper half cleared in 16-bit mode
  always_comb begin
    if (is_crc32) begin
      result_view = crc;
    end else begin
      result_view = {16'h0000, crc[15:0]};
    end
  end

  always_comb begin
    case (paddr[1:0])
      2'b00: addressed_byte = result_view[7:0];
      2'b01: addressed_byte = result_view[15:8];
      2'b10: addressed_byte = result_view[23:16];
      default: addressed_byte = result_view[31:24];
    endcase
  end

  // ***********************************
  // Register writes and CRC update
  // ***********************************
  always_comb begin
    next_cfg = cfg;
    next_seed = seed;
    next_crc = crc;
    if (wr_access && word_addr == `PCRC_OFS_CONFIG) begin
      next_cfg.poly_width_select = pwdata[`PCRC_POLY_HI:`PCRC_POLY_LO];
      next_cfg.bit_order_select = pwdata[`PCRC_BIT_ORDER];
      next_cfg.enable = pwdata[`PCRC_BIT_ENABLE];
    end
    if (wr_access && word_addr == `PCRC_OFS_SEED) begin
      next_seed = pwdata;
    end
    // With the engine disabled the CRC register holds its value: nothing reaches the CRC
    if (cfg.enable) begin
      if (wr_access && word_addr == `PCRC_OFS_SEED) begin
        next_crc = seed_loaded;
      end else if (data_write && mode_valid) begin
        next_crc = engine_out;
      end
    end
  end

  // ***********************************
  // Read path and APB answer
  // ***********************************
  // Read data is captured in the setup phase so prdata comes from a flop
  // and the access phase completes without wait states.
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_pready = 1'b1;
    if (setup) begin
      next_pslverr = ~pcrc_mapped(paddr);
      case (word_addr)
        `PCRC_OFS_CONFIG: begin
          next_prdata = 32'h00000000;
          next_prdata[`PCRC_POLY_HI:`PCRC_POLY_LO] = cfg.poly_width_select;
          next_prdata[`PCRC_BIT_ORDER] = cfg.bit_order_select;
          next_prdata[`PCRC_BIT_ENABLE] = cfg.enable;
        end
        `PCRC_OFS_WORD, `PCRC_OFS_HALF, `PCRC_OFS_BYTE:
          next_prdata = {24'h000000, addressed_byte};
        `PCRC_OFS_RESULT: next_prdata = result_view;
        `PCRC_OFS_SEED: next_prdata = seed;
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg <= pcrc_pkg::pcrc_cfg_t'(5'h00);
      crc <= `PCRC_RST_RESULT;
      seed <= `PCRC_RST_SEED;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      cfg <= next_cfg;
      crc <= next_crc;
      seed <= next_seed;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule

// >>> tb/pcrc_monitor.sv
// Checker for the CRC unit: APB answers and register readback.
// Assumes it is bound to pcrc_unit and sees only its ports.
`timescale 1ns/100ps
`include "pcrc_regs.svh"
module pcrc_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCRC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************
  // Shadow registers
  // ****************
  logic wr;
  logic rd;
  logic [31:0] seed_q;
  logic [6:0] cfg_q;
  logic [31:0] known;
  logic known_v;
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && penable && !pwrite;
  // Result is only predictable right after a plain 32-bit MSB-first seed load
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seed_q <= 32'h0;
      cfg_q <= 7'h0;
      known_v <= 1'b0;
    end else if (wr) begin
      if (paddr == `PCRC_OFS_SEED) seed_q <= pwdata;
      if (paddr == `PCRC_OFS_CONFIG) cfg_q <= pwdata[6:0] & 7'h75;
      known_v <= paddr == `PCRC_OFS_SEED && cfg_q == 7'h11;
      known <= pwdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_cfg_readback: assert property (rd && paddr == `PCRC_OFS_CONFIG |-> prdata == cfg_q)
    else $error("config readback wrong");
  chk_seed_readback: assert property (rd && paddr == `PCRC_OFS_SEED |-> prdata == seed_q)
    else $error("seed readback wrong");
  chk_byte_upper: assert property (rd && paddr >= 5'h04 && paddr < 5'h10 |-> prdata[31:8] == 24'h0)
    else $error("data register read not a byte");
  chk_half_view: assert property (rd && paddr == `PCRC_OFS_RESULT && cfg_q[6:4] != 3'h1
    |-> prdata[31:16] == 16'h0)
    else $error("16-bit result upper half set");
  chk_seed_load: assert property (rd && paddr == `PCRC_OFS_RESULT && known_v |-> prdata == known)
    else $error("seed not loaded");
  chk_unmapped_err: assert property (psel && penable && paddr >= 5'h18 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && paddr < 5'h18 |-> !pslverr)
    else $error("error on mapped access");
  chk_ready_up: assert property (clk_en |=> pready)
    else $error("pready low");
endmodule
bind pcrc_unit pcrc_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> tb/parallel_crc16_crc32_unit_test.sv
// Self-checking bench for the CRC unit over its APB port.
// Assumes clk_en stays high except in the hold scenario.
`timescale 1ns/100ps
`include "pcrc_regs.svh"
module parallel_crc16_crc32_unit_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] crc;
  logic [31:0] rd;
  logic wide;
  int failures = 0;
  int num_checks = 0;
  pcrc_unit i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial forever #20 core_clk = ~core_clk;
  // ****************
  // Helpers
  // ****************
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Leaves psel up so the next call makes a back-to-back transfer
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(negedge core_clk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge core_clk);
    penable = 1'b1;
    @(posedge core_clk);
    rd = prdata;
    check("pready", {31'h0, pready}, 32'h1);
    check("pslverr", {31'h0, pslverr}, {31'h0, a >= 5'h18});
  endtask
  task read_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // Serial reference: data bits enter LSB first, no final inversion
  function automatic logic [31:0] step(logic [31:0] c, logic [31:0] d, int n);
    logic fb;
    for (int i = 0; i < n; i++) begin
      fb = (wide ? c[31] : c[15]) ^ d[i];
      if (wide) c = (c << 1) ^ (fb ? `PCRC_POLY32 : 32'h0);
      else c[15:0] = (c[15:0] << 1) ^ (fb ? `PCRC_POLY16 : 16'h0);
    end
    return c;
  endfunction
  function automatic logic [31:0] view(logic [31:0] c);
    return wide ? c : {16'h0, c[15:0]};
  endfunction
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    read_chk("config", 5'h00, 32'h0);
    read_chk("result", 5'h10, 32'h0000FFFF);
    read_chk("seed", 5'h14, 32'h0);
    $display("test reset done");
  endtask
  task t_crc(input logic [31:0] cfg, input logic [31:0] seed, input logic [31:0] load);
    logic [31:0] dv [3];
    dv = '{32'hA5C30F81, 32'hDEAD1234, 32'hFFFFFF5A};
    xfer(1'b1, 5'h00, cfg);
    wide = cfg[4];
    read_chk("config", 5'h00, cfg & 32'h75);
    xfer(1'b1, 5'h14, seed);
    crc = load;
    read_chk("seed load", 5'h10, view(crc));
    read_chk("seed back", 5'h14, seed);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, 5'h04 + 5'(4 * k), dv[k]);
      crc = step(crc, dv[k], 32 >> k);
      read_chk("result", 5'h10, view(crc));
    end
    for (int k = 0; k < 4; k++) begin
      read_chk("crc byte", 5'h0C + 5'(k), {24'h0, 8'(view(crc) >> (8 * k))});
    end
    $display("test crc %h done", cfg);
  endtask
  task t_refuse;
    xfer(1'b1, 5'h00, 32'h00000010);
    xfer(1'b1, 5'h04, 32'h12345678);
    xfer(1'b1, 5'h00, 32'h00000021);
    xfer(1'b1, 5'h0C, 32'h000000C3);
    xfer(1'b1, 5'h10, 32'h0);
    xfer(1'b1, 5'h18, 32'hFFFFFFFF);
    read_chk("unmapped", 5'h1C, 32'h0);
    read_chk("reserved view", 5'h10, {16'h0, crc[15:0]});
    xfer(1'b1, 5'h00, 32'h00000011);
    read_chk("frozen", 5'h10, crc);
    $display("test refuse done");
  endtask
  // A data write made while clk_en is low must be lost; the bus is
  // released at the same negedge where clk_en returns so the stale access cannot complete
  task t_hold;
    @(negedge core_clk);
    clk_en = 1'b0;
    xfer(1'b1, 5'h04, 32'h0F0F0F0F);
    @(negedge core_clk);
    psel = 1'b0;
    penable = 1'b0;
    clk_en = 1'b1;
    read_chk("held", 5'h10, crc);
    $display("test hold done");
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_crc(32'hFFFFFF89, 32'h0000FFFF, 32'h0000FFFF);
    t_crc(32'h00000011, 32'hFFFFFFFF, 32'hFFFFFFFF);
    t_crc(32'h00000015, 32'h00000001, 32'h80000000);
    t_crc(32'h00000005, 32'h12340003, 32'h1234C000);
    t_refuse();
    t_hold();
    @(negedge core_clk);
    psel = 1'b0;
    penable = 1'b0;
    results();
  end
endmodule
